/* File: rtl/chan_cal_defs.vh */
`ifndef CHAN_CAL_DEFS_VH
`define CHAN_CAL_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_GLOBAL_DC_CTRL     6'h08
`define IDX_CHAN0_OFFSET_HIGH  6'h0A
`define IDX_CHAN0_OFFSET_LOW   6'h0B
`define IDX_CHAN0_GAIN_HIGH    6'h0C
`define IDX_CHAN0_GAIN_LOW     6'h0D
`define IDX_CHAN1_SETUP        6'h0E
`define IDX_CHAN1_OFFSET_HIGH  6'h0F

// Field positions.
`define LOW_BITS_MSB           15
`define LOW_BITS_LSB           8
`define PHASE_MSB              15
`define PHASE_LSB              6
`define DC_OFF_BIT             2
`define SELECT_MSB             1
`define SELECT_LSB             0
`define GLOBAL_DC_MSB          3
`define GLOBAL_DC_LSB          0

// Reset values.
`define RST_GAIN_HIGH          16'h8000
`define RST_GAIN_LOW           8'h00
`define RST_OFFSET_HIGH        16'h0000
`define RST_OFFSET_LOW         8'h00
`define RST_PHASE              10'h000
`define RST_DC_OFF             1'h0
`define RST_SELECT             2'h0
`define RST_GLOBAL_DC          4'h0

// Input select codes.
`define SEL_OWN_PINS           2'h0
`define SEL_SHORTED            2'h1
`define SEL_TEST_POS           2'h2
`define SEL_TEST_NEG           2'h3

// Gain of exactly one is 2^23; the product is shifted down by this.
`define GAIN_FRAC_BITS         23

// AXI4-Lite responses.
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

/* File: rtl/cal_datapath.v */
`timescale 1ns/1ns
`include "chan_cal_defs.vh"

module cal_datapath (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        reset_n,
  // Raw sample.
  input  wire [23:0] sample_in,
  input  wire        sample_in_valid,
  // Coefficients.
  input  wire [23:0] offset,
  input  wire [23:0] gain,
  // Corrected sample.
  output reg  [23:0] sample_out,
  output reg         sample_out_valid
);

  wire signed [24:0] diff;
  wire signed [49:0] product;
  wire signed [49:0] scaled;

  // Offset is removed first, then the unsigned gain scales the result.
  assign diff    = $signed({sample_in[23], sample_in}) -
                   $signed({offset[23], offset});
  assign product = diff * $signed({1'b0, gain});
  assign scaled  = product >>> `GAIN_FRAC_BITS;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sample_out       <= 24'h000000;
      sample_out_valid <= 1'b0;
    end else begin
      sample_out_valid <= sample_in_valid;
      if (sample_in_valid) begin
        // Results beyond 24 bits clip to the nearest full-scale code.
        if (scaled > $signed(50'h7FFFFF)) begin
          sample_out <= 24'h7FFFFF;
        end else if (scaled < -$signed(50'h800000)) begin
          sample_out <= 24'h800000;
        end else begin
          sample_out <= scaled[23:0];
        end
      end
    end
  end

endmodule

/* File: rtl/chan_route.v */
`timescale 1ns/1ns
`include "chan_cal_defs.vh"

module chan_route (
  // Clock and reset.
  input  wire       clk_sys,
  input  wire       reset_n,
  // Settings.
  input  wire [1:0] input_select,
  input  wire       dc_filter_off,
  input  wire [3:0] global_dc_setting,
  // Decoded controls.
  output reg  [3:0] dc_filter_setting,
  output reg        route_own_pins,
  output reg        route_shorted,
  output reg        route_test_pos,
  output reg        route_test_neg
);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dc_filter_setting <= 4'h0;
      route_own_pins    <= 1'b1;
      route_shorted     <= 1'b0;
      route_test_pos    <= 1'b0;
      route_test_neg    <= 1'b0;
    end else begin
      // A set disable bit bypasses the filter for this channel only.
      dc_filter_setting <= dc_filter_off ? 4'h0 : global_dc_setting;
      route_own_pins    <= (input_select == `SEL_OWN_PINS);
      route_shorted     <= (input_select == `SEL_SHORTED);
      route_test_pos    <= (input_select == `SEL_TEST_POS);
      route_test_neg    <= (input_select == `SEL_TEST_NEG);
    end
  end

endmodule

/* File: rtl/channel_calibration_config_regs.v */
// Functional notes
// - Offset high holds bits 23 to 8 of the signed 24-bit offset.
// - Offset low bits 15 to 8 hold offset bits 7 to 0 of the same value.
// - Gain high holds bits 23 to 8 of the unsigned 24-bit gain.
// - Gain low bits 15 to 8 hold gain bits 7 to 0.
// - The gain word is a factor from zero to just below two.
// - Gain high resets to 8000h for unity gain, gain low to zero.
// - Reserved bits are read-only and always read as zero.
// - The setup word bits 15 to 6 give a signed phase delay.
// - Setup bit 2 clear follows the global filter, set bypasses it.
// - Setup bits 1 to 0 pick own pins, shorted, or a test signal.
// - The channel 1 setup word sits at index 0Eh and resets to zero.
// - The global filter setting is bits 3 to 0 of its own register.
`timescale 1ns/1ns
`include "chan_cal_defs.vh"

module channel_calibration_config_regs (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        reset_n,
  // AXI4-Lite write address.
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data.
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response.
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address.
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data.
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Channel 0 sample path.
  input  wire [23:0] chan0_sample_in,
  input  wire        chan0_sample_in_valid,
  output wire [23:0] chan0_sample_out,
  output wire        chan0_sample_out_valid,
  // Channel 0 coefficients.
  output reg  [23:0] chan0_offset,
  output reg  [23:0] chan0_gain,
  // Channel 1 controls.
  output reg  [9:0]  chan1_phase_delay,
  output reg  [23:8] chan1_offset_high_bits,
  output wire [3:0]  chan1_dc_filter_setting,
  output wire        chan1_route_own_pins,
  output wire        chan1_route_shorted,
  output wire        chan1_route_test_pos,
  output wire        chan1_route_test_neg,
  // Global filter setting.
  output reg  [3:0]  global_dc_filter_setting
);

  // Stored fields.
  reg  [15:0] chan0_offset_high_bits;
  reg  [7:0]  chan0_offset_low_bits;
  reg  [15:0] chan0_gain_high_bits;
  reg  [7:0]  chan0_gain_low_bits;
  reg         chan1_dc_filter_off;
  reg  [1:0]  chan1_input_select;
  reg  [15:0] chan1_offset_high_store;
  reg  [9:0]  chan1_phase_store;
  reg  [3:0]  global_dc_store;

  // Write channel holding registers.
  reg         aw_held;
  reg  [5:0]  aw_index;
  reg         w_held;
  reg  [15:0] w_data;
  reg  [1:0]  w_strb;

  // Write decode.
  wire        do_write;
  reg  [15:0] write_old;
  reg         write_hit;
  reg  [15:0] merged;

  // Read decode.
  wire [5:0]  ar_index;
  reg  [15:0] read_word;
  reg         read_hit;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  // A write waits while its response is pending, so no answer is lost.
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign ar_index      = s_axi_araddr[7:2];

  // Current register image at the pending write index.
  always @* begin
    write_old = 16'h0000;
    write_hit = 1'b1;
    if (aw_index == `IDX_GLOBAL_DC_CTRL) begin
      write_old = {12'h000, global_dc_store};
    end else if (aw_index == `IDX_CHAN0_OFFSET_HIGH) begin
      write_old = chan0_offset_high_bits;
    end else if (aw_index == `IDX_CHAN0_OFFSET_LOW) begin
      write_old = {chan0_offset_low_bits, 8'h00};
    end else if (aw_index == `IDX_CHAN0_GAIN_HIGH) begin
      write_old = chan0_gain_high_bits;
    end else if (aw_index == `IDX_CHAN0_GAIN_LOW) begin
      write_old = {chan0_gain_low_bits, 8'h00};
    end else if (aw_index == `IDX_CHAN1_SETUP) begin
      write_old = {chan1_phase_store, 3'h0, chan1_dc_filter_off,
                   chan1_input_select};
    end else if (aw_index == `IDX_CHAN1_OFFSET_HIGH) begin
      write_old = chan1_offset_high_store;
    end else begin
      write_hit = 1'b0;
    end
  end

  // Byte lanes without a strobe keep their stored value.
  // Starting from the stored image means a one-lane write of a split
  // field cannot clear the half that the master did not mean to touch.
  always @* begin
    merged = write_old;
    if (w_strb[1]) begin
      merged[15:8] = w_data[15:8];
    end
    if (w_strb[0]) begin
      merged[7:0] = w_data[7:0];
    end
  end

  // Register image at the read index; reserved bits are zero.
  always @* begin
    read_word = 16'h0000;
    read_hit  = 1'b1;
    if (ar_index == `IDX_GLOBAL_DC_CTRL) begin
      read_word = {12'h000, global_dc_store};
    end else if (ar_index == `IDX_CHAN0_OFFSET_HIGH) begin
      read_word = chan0_offset_high_bits;
    end else if (ar_index == `IDX_CHAN0_OFFSET_LOW) begin
      read_word = {chan0_offset_low_bits, 8'h00};
    end else if (ar_index == `IDX_CHAN0_GAIN_HIGH) begin
      read_word = chan0_gain_high_bits;
    end else if (ar_index == `IDX_CHAN0_GAIN_LOW) begin
      read_word = {chan0_gain_low_bits, 8'h00};
    end else if (ar_index == `IDX_CHAN1_SETUP) begin
      read_word = {chan1_phase_store, 3'h0, chan1_dc_filter_off,
                   chan1_input_select};
    end else if (ar_index == `IDX_CHAN1_OFFSET_HIGH) begin
      read_word = chan1_offset_high_store;
    end else begin
      read_hit = 1'b0;
    end
  end

  // Write address and data are taken in either order and held.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held  <= 1'b0;
      aw_index <= 6'h00;
      w_held   <= 1'b0;
      w_data   <= 16'h0000;
      w_strb   <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held  <= 1'b1;
        aw_index <= s_axi_awaddr[7:2];
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[15:0];
        w_strb <= s_axi_wstrb[1:0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response is raised on the same edge as the register update.
  // An unmapped index is answered with an error so software sees the miss.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register updates; only defined fields are stored.
  // Reserved bits are never stored, so they cannot leak back on a read.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      global_dc_store         <= `RST_GLOBAL_DC;
      chan0_offset_high_bits  <= `RST_OFFSET_HIGH;
      chan0_offset_low_bits   <= `RST_OFFSET_LOW;
      chan0_gain_high_bits    <= `RST_GAIN_HIGH;
      chan0_gain_low_bits     <= `RST_GAIN_LOW;
      chan1_phase_store       <= `RST_PHASE;
      chan1_dc_filter_off     <= `RST_DC_OFF;
      chan1_input_select      <= `RST_SELECT;
      chan1_offset_high_store <= `RST_OFFSET_HIGH;
    end else if (do_write) begin
      if (aw_index == `IDX_GLOBAL_DC_CTRL) begin
        global_dc_store <= merged[`GLOBAL_DC_MSB:`GLOBAL_DC_LSB];
      end else if (aw_index == `IDX_CHAN0_OFFSET_HIGH) begin
        chan0_offset_high_bits <= merged;
      end else if (aw_index == `IDX_CHAN0_OFFSET_LOW) begin
        chan0_offset_low_bits <= merged[`LOW_BITS_MSB:`LOW_BITS_LSB];
      end else if (aw_index == `IDX_CHAN0_GAIN_HIGH) begin
        chan0_gain_high_bits <= merged;
      end else if (aw_index == `IDX_CHAN0_GAIN_LOW) begin
        chan0_gain_low_bits <= merged[`LOW_BITS_MSB:`LOW_BITS_LSB];
      end else if (aw_index == `IDX_CHAN1_SETUP) begin
        chan1_phase_store   <= merged[`PHASE_MSB:`PHASE_LSB];
        chan1_dc_filter_off <= merged[`DC_OFF_BIT];
        chan1_input_select  <= merged[`SELECT_MSB:`SELECT_LSB];
      end else if (aw_index == `IDX_CHAN1_OFFSET_HIGH) begin
        chan1_offset_high_store <= merged;
      end
    end
  end

  // The read image is decoded from araddr directly, so the address must
  // stand with arvalid until the edge that takes it.
  // Read data is registered; an unmapped index answers zero with SLVERR.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, read_word};
        s_axi_rresp  <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // A register stage here keeps the bus decode off the datapath timing.
  // Coefficients assembled from their register pairs.
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan0_offset             <= 24'h000000;
      chan0_gain               <= {`RST_GAIN_HIGH, `RST_GAIN_LOW};
      chan1_phase_delay        <= `RST_PHASE;
      chan1_offset_high_bits   <= `RST_OFFSET_HIGH;
      global_dc_filter_setting <= `RST_GLOBAL_DC;
    end else begin
      chan0_offset <= {chan0_offset_high_bits,
                       chan0_offset_low_bits};
      chan0_gain   <= {chan0_gain_high_bits,
                       chan0_gain_low_bits};
      chan1_phase_delay        <= chan1_phase_store;
      chan1_offset_high_bits   <= chan1_offset_high_store;
      global_dc_filter_setting <= global_dc_store;
    end
  end

  // Channel 0 correction always uses the registered coefficient pair.
  cal_datapath u_chan0_datapath (
    .clk_sys          (clk_sys),
    .reset_n          (reset_n),
    .sample_in        (chan0_sample_in),
    .sample_in_valid  (chan0_sample_in_valid),
    .offset           (chan0_offset),
    .gain             (chan0_gain),
    .sample_out       (chan0_sample_out),
    .sample_out_valid (chan0_sample_out_valid)
  );

  // Channel 1 routing follows the stored fields, never the raw bus word.
  chan_route u_chan1_route (
    .clk_sys           (clk_sys),
    .reset_n           (reset_n),
    .input_select      (chan1_input_select),
    .dc_filter_off     (chan1_dc_filter_off),
    .global_dc_setting (global_dc_store),
    .dc_filter_setting (chan1_dc_filter_setting),
    .route_own_pins    (chan1_route_own_pins),
    .route_shorted     (chan1_route_shorted),
    .route_test_pos    (chan1_route_test_pos),
    .route_test_neg    (chan1_route_test_neg)
  );

endmodule

/* File: test/chan_cal_properties.sv */
`timescale 1ns/1ns
// Watches the bus handshake, reserved read bits and the sample path.
module chan_cal_properties (
  // Clock and reset.
  input wire        clk_sys,
  input wire        reset_n,
  // Register bus.
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // Sample path and controls.
  input wire [23:0] chan0_sample_in,
  input wire        chan0_sample_in_valid,
  input wire [23:0] chan0_sample_out,
  input wire        chan0_sample_out_valid,
  input wire [23:0] chan0_offset,
  input wire [23:0] chan0_gain,
  input wire        chan1_route_own_pins,
  input wire        chan1_route_shorted,
  input wire        chan1_route_test_pos,
  input wire        chan1_route_test_neg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence unity_sample;
    chan0_sample_in_valid && chan0_gain == 24'h800000 && chan0_offset == 24'h0
    ##1 $stable(chan0_gain) && $stable(chan0_offset);
  endsequence
  write_answer_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  gain_reset_a: assert property ($rose(reset_n) |-> chan0_gain == 24'h800000)
    else $error("gain not unity after reset");
  route_onehot_a: assert property ($onehot({chan1_route_own_pins,
    chan1_route_shorted, chan1_route_test_pos, chan1_route_test_neg}))
    else $error("route not one-hot");
  sample_valid_a: assert property (chan0_sample_in_valid |=> chan0_sample_out_valid)
    else $error("sample out missing");
  sample_idle_a: assert property (!chan0_sample_in_valid |=> !chan0_sample_out_valid)
    else $error("spurious sample out");
  unity_pass_a: assert property (unity_sample |->
    chan0_sample_out == $past(chan0_sample_in)) else $error("unity gain altered");
endmodule

bind channel_calibration_config_regs chan_cal_properties i_chk (.*);

/* File: test/tb_channel_calibration_config_regs.sv */
`timescale 1ns/1ns
`include "chan_cal_defs.vh"
module tb_channel_calibration_config_regs;
  // Design inputs.
  logic        clk_sys, reset_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, chan0_sample_in_valid;
  logic [23:0] chan0_sample_in;
  // Design outputs.
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, chan0_sample_out_valid;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [23:0]  chan0_sample_out, chan0_offset, chan0_gain;
  wire [9:0]   chan1_phase_delay;
  wire [23:8]  chan1_offset_high_bits;
  wire [3:0]   chan1_dc_filter_setting, global_dc_filter_setting;
  wire         chan1_route_own_pins, chan1_route_shorted;
  wire         chan1_route_test_pos, chan1_route_test_neg;
  // Bench state.
  typedef struct packed {logic [7:0] a; logic [15:0] d, e; logic [1:0] r;} row_t;
  row_t        rows [0:7];
  logic [23:0] samp [0:3];
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          error_cnt, tests_run, i;

  channel_calibration_config_regs i_dut (.*);

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  task close_out;
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {16'hA5A5, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rd_reg(input [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Sends one sample and checks the corrected value one cycle later.
  task smp(input [23:0] v, input [23:0] e);
    @(posedge clk_sys);
    chan0_sample_in       <= v;
    chan0_sample_in_valid <= 1'b1;
    @(posedge clk_sys);
    chan0_sample_in_valid <= 1'b0;
    #1;
    chk(chan0_sample_out_valid, 1);
    chk(chan0_sample_out, e);
  endtask

  function [23:0] expect_out(input [23:0] x, input [23:0] o, input [23:0] g);
    logic signed [63:0] p;
    p = ($signed({{40{x[23]}}, x}) - $signed({{40{o[23]}}, o}))
        * $signed({40'h0, g});
    p = p >>> 23;
    if (p > 64'sh7FFFFF)
      expect_out = 24'h7FFFFF;
    else if (p < -64'sh800000)
      expect_out = 24'h800000;
    else
      expect_out = p[23:0];
  endfunction

  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, chan0_sample_in_valid, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, chan0_sample_in} = '0;
    s_axi_wstrb = 4'hF;
    rows[0] = '{8'h28, 16'hFFFF, 16'hFFFF, `RESP_OKAY};
    rows[1] = '{8'h2C, 16'hFFFF, 16'hFF00, `RESP_OKAY};
    rows[2] = '{8'h30, 16'hC000, 16'hC000, `RESP_OKAY};
    rows[3] = '{8'h34, 16'hABCD, 16'hAB00, `RESP_OKAY};
    rows[4] = '{8'h38, 16'hFFFF, 16'hFFC7, `RESP_OKAY};
    rows[5] = '{8'h3C, 16'h1234, 16'h1234, `RESP_OKAY};
    rows[6] = '{8'h20, 16'hFFFF, 16'h000F, `RESP_OKAY};
    rows[7] = '{8'h24, 16'hFFFF, 16'h0000, `RESP_SLVERR};
    samp = '{24'h7FFFFF, 24'h000100, 24'h800000, 24'hFFFF00};
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    smp(24'h123456, 24'h123456);
    for (i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      chk(rsp, rows[i].r);
      rd_reg(rows[i].a);
      chk(rd, rows[i].e);
      chk(rsp, rows[i].r);
    end
    chk(chan0_offset, 24'hFFFFFF);
    chk(chan0_gain, 24'hC000AB);
    chk(chan1_phase_delay, 10'h3FF);
    chk(chan1_offset_high_bits, 16'h1234);
    chk(global_dc_filter_setting, 4'hF);
    for (i = 0; i < 4; i++)
      smp(samp[i], expect_out(samp[i], 24'hFFFFFF, 24'hC000AB));
    for (i = 0; i < 4; i++) begin
      wr(8'h38, {13'h0, i[0], i[1:0]});
      repeat (3) @(posedge clk_sys);
      #1;
      chk({chan1_route_own_pins, chan1_route_shorted, chan1_route_test_pos,
           chan1_route_test_neg}, 4'h8 >> i);
      chk(chan1_dc_filter_setting, i[0] ? 4'h0 : 4'hF);
    end
    // Reset in mid-run returns every register to its reset value.
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(chan0_gain, 24'h800000);
    chk(chan1_route_own_pins, 1);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rd_reg(8'(8'h20 + 4 * i));
      chk(rd, (i == 4) ? 32'h8000 : 32'h0);
    end
    // Single byte lanes leave the other half of the word untouched.
    s_axi_wstrb <= 4'h2;
    wr(8'h3C, 16'hBEEF);
    rd_reg(8'h3C);
    chk(rd, 32'hBE00);
    s_axi_wstrb <= 4'h1;
    wr(8'h3C, 16'h1234);
    rd_reg(8'h3C);
    chk(rd, 32'hBE34);
    chk(chan1_offset_high_bits, 16'hBE34);
    close_out;
  end

  initial begin
    #200000;
    error_cnt++;
    close_out;
  end
endmodule
